/* File: verilog/rsv_supervisor.v */
// Functional notes
// - power, system and backup resets kept separate
// - power reset spares the backup domain
// - pin held low during power/system reset
// - flags survive all but power-on reset
// - clear bit wipes all source flags
// - every reset stretched to 20 us
// - three-bit low-voltage threshold select
// - detector works only when enabled
// - status bit shows supply below threshold while the detector is enabled
// - detector output drives event line 16
// - power-on/down comparators assert power reset
// - power-on/down supervision active only while the enable strap is high
// - brown-out reset unless select is 11
// - brown-out select encoding of three levels
// - pin released briefly, then held for brown-out
// - pull-down ineffective below 0.7 V
`timescale 1ns/1ps
`include "rsv_consts.vh"
module rsv_supervisor #(
  parameter [12:0] STRETCH_CYC = `RSV_STRETCH_CYC,
  parameter [3:0] BOR_GAP_CYC = `RSV_BOR_GAP_CYC
) (
  input wire aclk, // 250 MHz clock
  input wire aresetn, // sync reset, low
  input wire [31:0] s_axi_awaddr, // write address
  input wire s_axi_awvalid, // write address valid
  output reg s_axi_awready, // write address ready
  input wire [31:0] s_axi_wdata, // write data
  input wire [3:0] s_axi_wstrb, // byte strobes
  input wire s_axi_wvalid, // write data valid
  output reg s_axi_wready, // write data ready
  output reg [1:0] s_axi_bresp, // write response
  output reg s_axi_bvalid, // write response valid
  input wire s_axi_bready, // write response ready
  input wire [31:0] s_axi_araddr, // read address
  input wire s_axi_arvalid, // read address valid
  output reg s_axi_arready, // read address ready
  output reg [31:0] s_axi_rdata, // read data
  output reg [1:0] s_axi_rresp, // read response
  output reg s_axi_rvalid, // read data valid
  input wire s_axi_rready, // read data ready
  input wire por_above, // supply above power-on/down level
  input wire bor_below, // supply below brown-out level
  input wire [1:0] brownout_threshold_sel, // option byte
  input wire lvd_below, // supply below low-voltage level
  input wire supply_above_0v7, // pull-down transistor usable
  input wire supervisor_enable_pin, // board strap
  input wire reset_pin_i, // reset pin level
  input wire wdt_reset_req, // watchdog request, same clock
  output reg reset_pin_o, // reset pin drive value
  output reg reset_pin_oe, // reset pin pull-down on
  output reg power_reset_n, // power reset, low
  output reg system_reset_n, // system reset, low
  output reg backup_reset_n, // backup reset, low
  output reg [2:0] low_voltage_threshold_sel, // to comparator
  output reg lvd_event_line16 // event controller line 16
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  wire [7:0] pins_s;
  wire por_ok_s = pins_s[0];
  wire bor_low_s = pins_s[1];
  wire [1:0] bor_sel_s = pins_s[3:2];
  wire lvd_low_s = pins_s[4];
  wire mos_ok_s = pins_s[5];
  wire sup_en_s = pins_s[6];
  wire pin_s = pins_s[7];

  rsv_sync #(.W(8)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in({reset_pin_i, supervisor_enable_pin, supply_above_0v7,
      lvd_below, brownout_threshold_sel, bor_below, por_above}),
    .sync_out(pins_s)
  );

  // ----------------------------------------
  // reset requests
  // ----------------------------------------
  reg [4:0] flags;
  reg lvd_en;
  reg sw_sys_pulse;
  reg sw_bkp_pulse;
  reg [4:0] drive_hist;
  reg drive_d;
  wire drive_now;
  wire por_act, bor_act, sys_act, bkp_act;

  wire por_req = sup_en_s & ~por_ok_s;
  wire bor_req = (bor_sel_s != `RSV_BOR_OFF) & bor_low_s;
  // own drive and its echo through the synchroniser are not external
  wire ext_req = ~pin_s & ~drive_now & ~drive_d & ~(|drive_hist);
  wire sys_req = ext_req | sw_sys_pulse | wdt_reset_req;

  // ----------------------------------------
  // reset stretchers
  // ----------------------------------------
  // minimum pulse for every source
  rsv_stretch #(.CNT_W(13), .MIN_CYC(STRETCH_CYC), .ACT_RESET(1'b1)) u_por (
    .aclk(aclk),
    .aresetn(aresetn),
    .req(por_req),
    .active(por_act)
  );

  rsv_stretch #(.CNT_W(13), .MIN_CYC(STRETCH_CYC), .ACT_RESET(1'b0)) u_bor (
    .aclk(aclk),
    .aresetn(aresetn),
    .req(bor_req),
    .active(bor_act)
  );

  rsv_stretch #(.CNT_W(13), .MIN_CYC(STRETCH_CYC), .ACT_RESET(1'b0)) u_sys (
    .aclk(aclk),
    .aresetn(aresetn),
    .req(sys_req),
    .active(sys_act)
  );

  rsv_stretch #(.CNT_W(13), .MIN_CYC(STRETCH_CYC), .ACT_RESET(1'b0)) u_bkp (
    .aclk(aclk),
    .aresetn(aresetn),
    .req(sw_bkp_pulse),
    .active(bkp_act)
  );

  // ----------------------------------------
  // brown-out release gap on the pin
  // ----------------------------------------
  reg por_act_d;
  reg [3:0] gap_cnt;
  wire gap_busy = (gap_cnt != 4'h0);

  // short release when power-on ends under brown-out
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      por_act_d <= 1'b1;
      gap_cnt <= 4'h0;
    end
    else
    begin
      por_act_d <= por_act;
      if (por_act_d & ~por_act & bor_act)
        gap_cnt <= BOR_GAP_CYC;
      else if (gap_busy)
        gap_cnt <= gap_cnt - 4'h1;
    end
  end

  // pin low in power or system reset
  assign drive_now = por_act | (bor_act & ~gap_busy) | sys_act;

  // ----------------------------------------
  // reset outputs and pin drive
  // ----------------------------------------
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      reset_pin_o <= 1'b0;
      reset_pin_oe <= 1'b1;
      drive_d <= 1'b1;
      drive_hist <= 5'h1f;
      power_reset_n <= 1'b0;
      system_reset_n <= 1'b0;
      backup_reset_n <= 1'b1;
    end
    else
    begin
      reset_pin_o <= 1'b0;
      reset_pin_oe <= drive_now & mos_ok_s;
      drive_d <= drive_now;
      drive_hist <= {drive_hist[3:0], drive_d};
      // backup reset not touched by power reset
      power_reset_n <= ~(por_act | bor_act);
      system_reset_n <= ~(por_act | bor_act | sys_act);
      backup_reset_n <= ~bkp_act;
    end
  end

  // ----------------------------------------
  // low-voltage detector
  // ----------------------------------------
  // inactive unless enabled
  // level to event line 16, edges picked there
  always @(posedge aclk)
  begin
    if (!aresetn)
      lvd_event_line16 <= 1'b0;
    else
      lvd_event_line16 <= lvd_en & lvd_low_s;
  end

  // ----------------------------------------
  // reset-source flags
  // ----------------------------------------
  reg por_req_d, bor_req_d, ext_req_d;
  reg flag_clear;
  reg [4:0] next_flags;

  // set wins over a clear in the same cycle
  always @*
  begin
    next_flags = flag_clear ? 5'h00 : flags;
    if (por_req & ~por_req_d)
      next_flags = 5'h00;
    if (por_req & ~por_req_d)
      next_flags[`RSV_FLG_POR] = 1'b1;
    if (bor_req & ~bor_req_d)
      next_flags[`RSV_FLG_BOR] = 1'b1;
    if (ext_req & ~ext_req_d)
      next_flags[`RSV_FLG_PIN] = 1'b1;
    if (sw_sys_pulse)
      next_flags[`RSV_FLG_SW] = 1'b1;
    if (wdt_reset_req)
      next_flags[`RSV_FLG_WDT] = 1'b1;
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      flags <= `RSV_FLAGS_RESET;
      por_req_d <= 1'b1;
      bor_req_d <= 1'b0;
      ext_req_d <= 1'b0;
    end
    else
    begin
      flags <= next_flags;
      por_req_d <= por_req;
      bor_req_d <= bor_req;
      ext_req_d <= ext_req;
    end
  end

  // ----------------------------------------
  // bus write channel
  // ----------------------------------------
  reg [31:0] wr_addr;
  reg [31:0] wr_data;
  reg [3:0] wr_strb;
  wire wr_go = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;

  function hit;
    input [31:0] a;
    begin
      hit = (a == `RSV_ADDR_FLAGS) | (a == `RSV_ADDR_PWR_CTL) |
        (a == `RSV_ADDR_PWR_STAT) | (a == `RSV_ADDR_SOFT_RST);
    end
  endfunction

  // ready low means held; write fires once both halves are held
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RSV_RESP_OKAY;
      wr_addr <= 32'h0000_0000;
      wr_data <= 32'h0000_0000;
      wr_strb <= 4'h0;
      lvd_en <= 1'b0;
      low_voltage_threshold_sel <= `RSV_LVD_SEL_RESET;
      flag_clear <= 1'b0;
      sw_sys_pulse <= 1'b0;
      sw_bkp_pulse <= 1'b0;
    end
    else
    begin
      flag_clear <= 1'b0;
      sw_sys_pulse <= 1'b0;
      sw_bkp_pulse <= 1'b0;
      if (s_axi_awvalid & s_axi_awready)
      begin
        wr_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready)
      begin
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= hit(wr_addr) ? `RSV_RESP_OKAY : `RSV_RESP_SLVERR;
        // write one to clear all flags
        if (wr_addr == `RSV_ADDR_FLAGS && wr_strb[3])
          flag_clear <= wr_data[`RSV_FLG_CLEAR];
        if (wr_addr == `RSV_ADDR_PWR_CTL && wr_strb[0])
        begin
          lvd_en <= wr_data[`RSV_CTL_LVD_EN];
          low_voltage_threshold_sel <= wr_data[`RSV_CTL_LVD_SEL_LO +: 3];
        end
        if (wr_addr == `RSV_ADDR_SOFT_RST && wr_strb[0])
        begin
          sw_sys_pulse <= wr_data[`RSV_SOFT_SYS];
          sw_bkp_pulse <= wr_data[`RSV_SOFT_BKP];
        end
      end
      if (s_axi_bvalid & s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // bus read channel
  // ----------------------------------------
  reg [31:0] rd_word;

  always @*
  begin
    rd_word = 32'h0000_0000;
    case (s_axi_araddr)
      `RSV_ADDR_FLAGS: rd_word[4:0] = flags;
      `RSV_ADDR_PWR_CTL: rd_word[3:0] = {low_voltage_threshold_sel, lvd_en};
      `RSV_ADDR_PWR_STAT: rd_word[`RSV_STAT_LVD_FLAG] = lvd_event_line16;
      default: rd_word = 32'h0000_0000;
    endcase
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RSV_RESP_OKAY;
    end
    else if (s_axi_arvalid & s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= hit(s_axi_araddr) ? `RSV_RESP_OKAY : `RSV_RESP_SLVERR;
    end
    else if (s_axi_rvalid & s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule // rsv_supervisor

/* File: pkg/rsv_consts.vh */
`ifndef RSV_CONSTS_VH
`define RSV_CONSTS_VH

// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define RSV_ADDR_FLAGS 32'h4002_3874
`define RSV_ADDR_PWR_CTL 32'h4002_3880
`define RSV_ADDR_PWR_STAT 32'h4002_3884
`define RSV_ADDR_SOFT_RST 32'h4002_3888

// ----------------------------------------
// field positions
// ----------------------------------------
`define RSV_FLG_POR 0
`define RSV_FLG_BOR 1
`define RSV_FLG_PIN 2
`define RSV_FLG_SW 3
`define RSV_FLG_WDT 4
`define RSV_FLG_CLEAR 24
`define RSV_CTL_LVD_EN 0
`define RSV_CTL_LVD_SEL_LO 1
`define RSV_STAT_LVD_FLAG 0
`define RSV_SOFT_SYS 0
`define RSV_SOFT_BKP 1

// ----------------------------------------
// reset values and codes
// ----------------------------------------
`define RSV_FLAGS_RESET 5'h01
`define RSV_LVD_SEL_RESET 3'h0
`define RSV_BOR_OFF 2'b11
`define RSV_RESP_OKAY 2'b00
`define RSV_RESP_SLVERR 2'b10

// ----------------------------------------
// timing
// ----------------------------------------
`define RSV_CLK_MHZ 250
`define RSV_STRETCH_NS 20000
// 20000 ns at 250 MHz, sized to the 13-bit stretch counter
`define RSV_STRETCH_CYC 13'h1388
`define RSV_BOR_GAP_CYC 4'h4

`endif

/* File: verilog/rsv_sync.v */
`timescale 1ns/1ps
module rsv_sync #(
  parameter W = 1
) (
  input wire aclk, // clock
  input wire aresetn, // sync reset, low
  input wire [W-1:0] async_in, // pin levels
  output reg [W-1:0] sync_out // synchronised levels
);

  reg [W-1:0] meta;

  // two-stage synchroniser, first stage read only by second
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta <= {W{1'b0}};
      sync_out <= {W{1'b0}};
    end
    else
    begin
      meta <= async_in;
      sync_out <= meta;
    end
  end

endmodule // rsv_sync

/* File: verilog/rsv_stretch.v */
`timescale 1ns/1ps
module rsv_stretch #(
  parameter CNT_W = 13,
  parameter [CNT_W-1:0] MIN_CYC = 13'h1388,
  parameter ACT_RESET = 1'b0
) (
  input wire aclk, // clock
  input wire aresetn, // sync reset, low
  input wire req, // reset request level
  output reg active // stretched reset, high
);

  reg [CNT_W-1:0] cnt;

  // reload while requested, then hold for the minimum length
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      active <= ACT_RESET;
      cnt <= ACT_RESET ? MIN_CYC : {CNT_W{1'b0}};
    end
    else if (req)
    begin
      active <= 1'b1;
      cnt <= MIN_CYC;
    end
    else if (cnt > {{(CNT_W-1){1'b0}}, 1'b1})
    begin
      cnt <= cnt - {{(CNT_W-1){1'b0}}, 1'b1};
    end
    else
    begin
      cnt <= {CNT_W{1'b0}};
      active <= 1'b0;
    end
  end

endmodule // rsv_stretch

/* File: tb/rsv_rail_model.sv */
`timescale 1ns/1ps
// ----------------------------------------
// reset pin network and board strap
// ----------------------------------------
module rsv_rail_model (
  input wire reset_pin_o, // device drive value
  input wire reset_pin_oe, // device pull-down on
  input wire ext_press_n, // push button, low
  output wire reset_pin_i, // resolved pin level
  output wire supervisor_enable_pin // board strap
);
  assign supervisor_enable_pin = 1'b1;
  // pull-up wins unless a party pulls low
  assign reset_pin_i = !((reset_pin_oe && !reset_pin_o) || !ext_press_n);
endmodule // rsv_rail_model

/* File: tb/rsv_supervisor_sva.sv */
`timescale 1ns/1ps
// ----------------------------------------
// supervisor port checker
// ----------------------------------------
module rsv_supervisor_sva #(
  parameter [12:0] STRETCH_CYC = 13'h1388,
  parameter [3:0] BOR_GAP_CYC = 4'h4
) (
  input wire aclk, // clock
  input wire aresetn, // sync reset, low
  input wire s_axi_bvalid, // resp valid
  input wire s_axi_bready, // resp ready
  input wire [1:0] s_axi_bresp, // resp code
  input wire por_above, // supply ok
  input wire bor_below, // under brown-out
  input wire [1:0] brownout_threshold_sel, // option
  input wire lvd_below, // under detect level
  input wire supply_above_0v7, // pull-down usable
  input wire supervisor_enable_pin, // strap
  input wire reset_pin_oe, // pin pull-down
  input wire power_reset_n, // power reset
  input wire system_reset_n, // system reset
  input wire backup_reset_n, // backup reset
  input wire lvd_event_line16 // event line
);
  reg [15:0] sys_lo;
  reg [15:0] pwr_lo;
  reg [2:0] det_lo;

  // low-run lengths, cleared in reset so no unknown leaks in
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sys_lo <= 16'h0000;
      pwr_lo <= 16'h0000;
      det_lo <= 3'h0;
    end
    else
    begin
      sys_lo <= system_reset_n ? 16'h0000 : sys_lo + 16'h0001;
      pwr_lo <= power_reset_n ? 16'h0000 : pwr_lo + 16'h0001;
      det_lo <= lvd_below ? 3'h0 : det_lo + {2'h0, det_lo != 3'h7};
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_pin_low;
    (power_reset_n && !system_reset_n && supply_above_0v7) [*6] |-> reset_pin_oe;
  endproperty
  a_pin_low: assert property (p_pin_low)
    else $error("pin not pulled during system reset");
  property p_sys_str;
    $rose(system_reset_n) |-> sys_lo >= STRETCH_CYC;
  endproperty
  a_sys_str: assert property (p_sys_str)
    else $error("system reset too short");
  property p_pwr_str;
    $rose(power_reset_n) |-> pwr_lo >= STRETCH_CYC;
  endproperty
  a_pwr_str: assert property (p_pwr_str)
    else $error("power reset too short");
  property p_supply_low;
    (!por_above && supervisor_enable_pin) [*8] |-> !power_reset_n;
  endproperty
  a_supply_low: assert property (p_supply_low)
    else $error("no power reset on low supply");
  property p_brown;
    (bor_below && brownout_threshold_sel != 2'b11) [*8] |-> !power_reset_n;
  endproperty
  a_brown: assert property (p_brown)
    else $error("no power reset on brown-out");
  property p_bkp;
    $fell(backup_reset_n) |-> power_reset_n;
  endproperty
  a_bkp: assert property (p_bkp)
    else $error("backup reset started by power reset");
  property p_event;
    lvd_event_line16 |-> det_lo < 3'h7;
  endproperty
  a_event: assert property (p_event)
    else $error("event line high with supply fine");
  property p_dim;
    (!supply_above_0v7) [*5] |-> !reset_pin_oe;
  endproperty
  a_dim: assert property (p_dim)
    else $error("pull-down on below usable supply");
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold)
    else $error("write response dropped early");
endmodule // rsv_supervisor_sva

bind rsv_supervisor rsv_supervisor_sva #(.STRETCH_CYC(STRETCH_CYC), .BOR_GAP_CYC(BOR_GAP_CYC))
  i_rsv_supervisor_sva (.aclk, .aresetn, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
  .por_above, .bor_below, .brownout_threshold_sel, .lvd_below, .supply_above_0v7,
  .supervisor_enable_pin, .reset_pin_oe, .power_reset_n, .system_reset_n,
  .backup_reset_n, .lvd_event_line16);

/* File: tb/testbench.sv */
`timescale 1ns/1ps
`include "rsv_consts.vh"
module testbench;
  localparam int STR = 20;
  typedef struct packed {logic wr; logic [31:0] a; logic [31:0] d; logic [1:0] r;} rsv_row_t;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0000_0000, s_axi_wdata = 32'h0000_0000;
  logic [31:0] s_axi_araddr = 32'h0000_0000, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic por_above = 1'b1, bor_below = 1'b0, lvd_below = 1'b0, supply_above_0v7 = 1'b1;
  logic wdt_reset_req = 1'b0, ext_press_n = 1'b1;
  logic [1:0] brownout_threshold_sel = 2'b11, s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic reset_pin_o, reset_pin_oe, reset_pin_i, supervisor_enable_pin;
  logic power_reset_n, system_reset_n, backup_reset_n, lvd_event_line16;
  logic [2:0] low_voltage_threshold_sel;
  int bad_count = 0, checks_done = 0;
  // register cases: read rows compare data and response
  rsv_row_t rows [8] = '{
    '{1'b0, `RSV_ADDR_FLAGS, 32'h0000_0001, `RSV_RESP_OKAY},
    '{1'b1, `RSV_ADDR_PWR_CTL, 32'h0000_000F, `RSV_RESP_OKAY}, // top level
    '{1'b0, `RSV_ADDR_PWR_CTL, 32'h0000_000F, `RSV_RESP_OKAY},
    '{1'b0, `RSV_ADDR_PWR_STAT, 32'h0000_0000, `RSV_RESP_OKAY},
    '{1'b0, 32'h4002_3890, 32'h0000_0000, `RSV_RESP_SLVERR},
    '{1'b1, 32'h4002_3890, 32'h0000_0000, `RSV_RESP_SLVERR},
    '{1'b1, `RSV_ADDR_FLAGS, 32'h0100_0000, `RSV_RESP_OKAY},
    '{1'b0, `RSV_ADDR_FLAGS, 32'h0000_0000, `RSV_RESP_OKAY}};

  rsv_supervisor #(.STRETCH_CYC(13'h0014), .BOR_GAP_CYC(4'h4)) i_rsv_supervisor (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .por_above, .bor_below,
    .brownout_threshold_sel, .lvd_below, .supply_above_0v7, .supervisor_enable_pin,
    .reset_pin_i, .wdt_reset_req, .reset_pin_o, .reset_pin_oe, .power_reset_n,
    .system_reset_n, .backup_reset_n, .low_voltage_threshold_sel, .lvd_event_line16);
  rsv_rail_model i_rsv_rail_model (.reset_pin_o, .reset_pin_oe, .ext_press_n,
    .reset_pin_i, .supervisor_enable_pin);

  // 250 MHz clock
  always #2 aclk = ~aclk;

  // ----------------------------------------
  // checking and bus tasks
  // ----------------------------------------
  task end_sim;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] s, e);
    checks_done++;
    if (s !== e)
    begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  // a wait that ran out ends the run
  task tmo(input logic ok);
    if (ok !== 1'b1)
    begin
      chk(32'(ok), 32'h0000_0001);
      end_sim;
    end
  endtask
  function logic sig(input int s);
    case (s)
      0: sig = system_reset_n;
      1: sig = power_reset_n;
      2: sig = reset_pin_oe;
      default: sig = backup_reset_n;
    endcase
  endfunction
  task wait_for(input int s, input logic v);
    int i;
    for (i = 0; i < 400 && sig(s) !== v; i++)
      @(posedge aclk);
    tmo(sig(s) === v);
  endtask
  // master holds each channel until its own ready
  task axi_wr(input logic [31:0] a, d, input logic [1:0] r);
    int i;
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 60 && s_axi_bvalid !== 1'b1; i++)
    begin
      @(posedge aclk);
      aw = aw | (s_axi_awready === 1'b1);
      w = w | (s_axi_wready === 1'b1);
      s_axi_awvalid <= !aw;
      s_axi_wvalid <= !w;
    end
    s_axi_bready <= 1'b0;
    tmo(s_axi_bvalid);
    chk(32'(s_axi_bresp), 32'(r));
  endtask
  task axi_rd(input logic [31:0] a, e, input logic [1:0] r);
    int i;
    logic ar;
    ar = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 60 && s_axi_rvalid !== 1'b1; i++)
    begin
      @(posedge aclk);
      ar = ar | (s_axi_arready === 1'b1);
      s_axi_arvalid <= !ar;
    end
    s_axi_rready <= 1'b0;
    tmo(s_axi_rvalid);
    chk(s_axi_rdata, e);
    chk(32'(s_axi_rresp), 32'(r));
  endtask
  // one system reset: pin level, then stretched length
  task sys_pulse(input logic pin);
    int n;
    wait_for(0, 1'b0);
    repeat (2) @(posedge aclk);
    chk(32'(reset_pin_i), 32'(pin));
    chk(32'(reset_pin_o), 32'h0000_0000);
    for (n = 2; n < 400 && system_reset_n !== 1'b1; n++)
      @(posedge aclk);
    chk(32'(n >= STR), 32'h0000_0001);
  endtask
  task done(input string n);
    $display("test %s finished", n);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    repeat (3) @(posedge aclk);
    chk(32'(power_reset_n), 32'h0000_0000);
    chk(32'(backup_reset_n), 32'h0000_0001);
    chk(32'(reset_pin_oe), 32'h0000_0001);
    aresetn <= 1'b1;
    wait_for(1, 1'b1);
    wait_for(0, 1'b1);
    foreach (rows[k])
      if (rows[k].wr)
        axi_wr(rows[k].a, rows[k].d, rows[k].r);
      else
        axi_rd(rows[k].a, rows[k].d, rows[k].r);
    done("registers");
    chk(32'(low_voltage_threshold_sel), 32'h0000_0007);
    lvd_below <= 1'b1;
    repeat (8) @(posedge aclk);
    chk(32'(lvd_event_line16), 32'h0000_0001);
    axi_rd(`RSV_ADDR_PWR_STAT, 32'h0000_0001, `RSV_RESP_OKAY);
    axi_wr(`RSV_ADDR_PWR_CTL, 32'h0000_000E, `RSV_RESP_OKAY);
    repeat (6) @(posedge aclk);
    chk(32'(lvd_event_line16), 32'h0000_0000);
    axi_rd(`RSV_ADDR_PWR_STAT, 32'h0000_0000, `RSV_RESP_OKAY);
    lvd_below <= 1'b0;
    done("detector");
    wdt_reset_req <= 1'b1;
    @(posedge aclk);
    wdt_reset_req <= 1'b0;
    sys_pulse(1'b0);
    axi_rd(`RSV_ADDR_FLAGS, 32'h0000_0010, `RSV_RESP_OKAY);
    // one-cycle press: the stretcher alone must make the full pulse
    ext_press_n <= 1'b0;
    @(posedge aclk);
    ext_press_n <= 1'b1;
    sys_pulse(1'b0);
    axi_rd(`RSV_ADDR_FLAGS, 32'h0000_0014, `RSV_RESP_OKAY);
    axi_wr(`RSV_ADDR_SOFT_RST, 32'h0000_0001, `RSV_RESP_OKAY);
    sys_pulse(1'b0);
    axi_rd(`RSV_ADDR_FLAGS, 32'h0000_001C, `RSV_RESP_OKAY);
    done("system resets");
    axi_wr(`RSV_ADDR_SOFT_RST, 32'h0000_0002, `RSV_RESP_OKAY);
    wait_for(3, 1'b0);
    chk(32'(power_reset_n), 32'h0000_0001);
    wait_for(3, 1'b1);
    supply_above_0v7 <= 1'b0;
    wdt_reset_req <= 1'b1;
    @(posedge aclk);
    wdt_reset_req <= 1'b0;
    sys_pulse(1'b1);
    supply_above_0v7 <= 1'b1;
    done("backup and weak supply");
    for (int s = 0; s < 4; s++)
    begin
      @(posedge aclk);
      brownout_threshold_sel <= 2'(s);
      bor_below <= 1'b1;
      repeat (12) @(posedge aclk);
      chk(32'(power_reset_n), 32'(s == 3));
      bor_below <= 1'b0;
      wait_for(1, 1'b1);
      wait_for(0, 1'b1);
    end
    axi_rd(`RSV_ADDR_FLAGS, 32'h0000_001E, `RSV_RESP_OKAY);
    brownout_threshold_sel <= 2'b11;
    por_above <= 1'b0;
    repeat (10) @(posedge aclk);
    chk(32'(power_reset_n), 32'h0000_0000);
    por_above <= 1'b1;
    wait_for(1, 1'b1);
    wait_for(0, 1'b1);
    axi_rd(`RSV_ADDR_FLAGS, 32'h0000_0001, `RSV_RESP_OKAY);
    brownout_threshold_sel <= 2'b00;
    bor_below <= 1'b1;
    por_above <= 1'b0;
    repeat (10) @(posedge aclk);
    por_above <= 1'b1;
    wait_for(2, 1'b0);
    repeat (6) @(posedge aclk);
    chk(32'(reset_pin_oe), 32'h0000_0001);
    bor_below <= 1'b0;
    wait_for(1, 1'b1);
    done("power resets");
    end_sim;
  end
endmodule // testbench
